//--- rtl/ud_pkg.sv
package ud_pkg;

	// ****************************************
	// register addresses on the parallel bus
	// ****************************************
	localparam logic [2:0] A_THR_DLL = 3'h0;
	localparam logic [2:0] A_IER_DLH = 3'h1;
	localparam logic [2:0] A_FCR_EFR = 3'h2;
	localparam logic [2:0] A_LCR     = 3'h3;
	localparam logic [2:0] A_MCR     = 3'h4;
	localparam logic [2:0] A_LSR     = 3'h5;
	localparam logic [2:0] A_STAT    = 3'h7;

	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned IER_SLEEP = 4;
	localparam int unsigned EFR_ENH   = 4;
	localparam int unsigned LCR_BRK   = 6;
	localparam int unsigned LCR_DLAB  = 7;
	localparam int unsigned FCR_EN    = 0;
	localparam int unsigned FCR_DMA   = 3;
	localparam int unsigned MCR_PRE   = 7;

	// ****************************************
	// reset values and constants
	// ****************************************
	localparam logic [7:0] LCR_RST     = 8'h1D;
	localparam logic [7:0] REG_RST     = 8'h00;
	localparam logic [7:0] LCR_EFR_KEY = 8'hBF;
	localparam logic [5:0] IDLE_BASE   = 6'h20;
	localparam logic [3:0] MID_PHASE   = 4'h7;
	localparam logic [1:0] PRE_LAST    = 2'h3;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		SLP_AWAKE  = 2'b01,
		SLP_ASLEEP = 2'b10
	} ud_slp_e;

	typedef struct packed {
		logic       rx;
		logic [3:0] mdm;
		logic [7:0] d;
		logic [2:0] a;
		logic       cs_b;
		logic       rd_b;
		logic       wr_b;
	} ud_pins_s;

	typedef struct packed {
		logic [6:0] tx_free;
		logic [6:0] tx_trig;
		logic       tx_full;
		logic       tx_empty;
		logic       tsr_empty;
		logic [6:0] rx_count;
		logic [6:0] rx_trig;
		logic       rx_timeout;
		logic       rx_err;
		logic       irq_other;
	} ud_fifo_s;

endpackage : ud_pkg

//--- rtl/ud_baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
module ud_baud_gen
	import ud_pkg::*;
(
	input  wire logic        clk_i,     // system clock
	input  wire logic        rst_b_i,   // sync reset, low
	input  wire logic        run_i,     // clock allowed (awake)
	input  wire logic        pre4_i,    // divide input by 4
	input  wire logic [15:0] divisor_i, // programmed divisor
	input  wire logic        load_i,    // reload request
	output logic             tick16_o,  // 16x baud pulse
	output logic             loaded_o   // reload done pulse
);
	typedef struct packed {
		logic [1:0]  pre;
		logic [15:0] cnt;
		logic        tick;
		logic        ack;
	} ud_bg_s;

	ud_bg_s q;
	ud_bg_s next_q;
	logic   pen;

	// ****************************************
	// prescaler and down counter
	// ****************************************
	// a zero divisor never ticks, which parks the whole channel
	always_comb begin
		next_q = q;
		next_q.tick = 1'b0;
		next_q.ack = 1'b0;
		pen = !pre4_i || (q.pre == PRE_LAST);
		if (load_i) begin
			next_q.cnt = divisor_i;
			next_q.pre = 2'h0;
			next_q.ack = 1'b1;
		end else if (run_i && divisor_i != 16'h0000) begin
			if (pre4_i) begin
				next_q.pre = q.pre + 2'h1;
			end
			if (pen) begin
				if (q.cnt <= 16'h0001) begin
					next_q.cnt = divisor_i;
					next_q.tick = 1'b1;
				end else begin
					next_q.cnt = q.cnt - 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign tick16_o = q.tick;
	assign loaded_o = q.ack;

	chk_zero_div_silent: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(divisor_i == 16'h0000)[*2] |-> !tick16_o)
		else $error("baud tick with zero divisor");

	chk_div_one_rate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(run_i && !pre4_i && !load_i && divisor_i == 16'h0001)[*3] |-> tick16_o)
		else $error("divisor one must tick every cycle");

endmodule : ud_baud_gen
`default_nettype wire

//--- rtl/ud_rx_idle.sv
`timescale 1ns/1ps
`default_nettype none
module ud_rx_idle
	import ud_pkg::*;
(
	input  wire logic       clk_i,    // system clock
	input  wire logic       rst_b_i,  // sync reset, low
	input  wire logic       tick16_i, // 16x baud pulse
	input  wire logic       rx_i,     // synchronised serial in
	input  wire logic [1:0] wlen_i,   // word length code
	output logic            idle_o    // line idle level
);
	typedef struct packed {
		logic [3:0] phase;
		logic [5:0] bits;
		logic       idle;
	} ud_idle_s;

	ud_idle_s   q;
	ud_idle_s   next_q;
	logic [5:0] limit;

	// ****************************************
	// mid-bit sampling and high-bit count
	// ****************************************
	// free-running phase; a low sample anywhere restarts the count
	always_comb begin
		next_q = q;
		limit = IDLE_BASE + {2'b00, wlen_i, 2'b00};
		if (tick16_i) begin
			next_q.phase = q.phase + 4'h1;
			if (q.phase == MID_PHASE) begin
				if (!rx_i) begin
					next_q.bits = 6'h00;
				end else if (q.bits != 6'h3F) begin
					next_q.bits = q.bits + 6'h01;
				end
			end
		end
		next_q.idle = (next_q.bits >= limit);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign idle_o = q.idle;

	chk_idle_low_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(tick16_i && q.phase == MID_PHASE && !rx_i) |=> !idle_o)
		else $error("idle held after low sample");

endmodule : ud_rx_idle
`default_nettype wire

//--- rtl/ud_uart_ctl.sv
`timescale 1ns/1ps
`default_nettype none

module ud_uart_ctl
	import ud_pkg::*;
(
	input  wire logic            clk_i,             // 50 MHz clock
	input  wire logic            rst_b_i,           // sync reset, low
	input  wire logic            cs_b_i,            // chip select pin, low
	input  wire logic            rd_b_i,            // read strobe pin, low
	input  wire logic            wr_b_i,            // write strobe pin, low
	input  wire logic [2:0]      a_i,               // register address pins
	input  wire logic [7:0]      d_i,               // data bus in
	output logic      [7:0]      d_o,               // data bus out
	output logic                 d_oe_o,            // data bus drive enable
	output logic                 bus_wait_o,        // wait state, high
	input  wire logic            rx_i,              // serial input pin
	input  wire logic [3:0]      modem_i,           // modem input pins
	input  wire logic            tx_data_i,         // transmitter serial bit
	output logic                 tx_serial_o,       // serial output pin
	input  wire ud_pkg::ud_fifo_s fifo_i,           // fifo status, same clock
	output logic                 thr_write_o,       // transmit holding write pulse
	output logic      [7:0]      thr_data_o,        // transmit holding data
	output logic                 tx_dma_request_b_o, // tx dma request, low
	output logic                 rx_dma_request_b_o, // rx dma request, low
	output logic                 baud_tick16_o,     // shared 16x tick
	output logic                 uart_clk_en_o,     // uart clock enable
	output logic                 rx_idle_o,         // receive line idle
	output logic                 asleep_o           // sleep state
);
	typedef struct packed {
		ud_pins_s   sy1;
		ud_pins_s   sy2;
		ud_pins_s   prv;
		logic [7:0] interrupt_enable_reg;
		logic [7:0] line_control_reg;
		logic [7:0] fifo_control_reg;
		logic [7:0] modem_control_reg;
		logic [7:0] enhanced_feature_reg;
		logic [7:0] dll;
		logic [7:0] divisor_high_byte;
		logic       txrq;
		logic       rxrq;
		ud_slp_e    slp;
		logic       load;
		logic       wt;
		logic       thr_wr;
		logic [7:0] thr_d;
		logic [7:0] dout;
		logic       txo;
	} ud_top_s;

	ud_top_s    q;
	ud_top_s    next_q;
	ud_pins_s   pins;
	logic       tick16;
	logic       loaded;
	logic       rx_idle;
	logic       wr_edge;
	logic       single;
	logic       allowed;
	logic       quiet;
	logic       wake;
	logic       rx_held;
	logic [7:0] lsr_view;
	logic [7:0] rd_mux;

	// ****************************************
	// pin gathering
	// ****************************************
	assign pins = '{rx: rx_i, mdm: modem_i, d: d_i, a: a_i,
		cs_b: cs_b_i, rd_b: rd_b_i, wr_b: wr_b_i};

	// ****************************************
	// submodules
	// ****************************************
	// one generator feeds both directions, so they cannot drift apart
	ud_baud_gen u_baud (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.run_i     (q.slp == SLP_AWAKE),
		.pre4_i    (q.modem_control_reg[MCR_PRE]),
		.divisor_i ({q.divisor_high_byte, q.dll}),
		.load_i    (q.load),
		.tick16_o  (tick16),
		.loaded_o  (loaded)
	);

	ud_rx_idle u_idle (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.tick16_i (tick16),
		.rx_i     (q.sy2.rx),
		.wlen_i   (q.line_control_reg[1:0]),
		.idle_o   (rx_idle)
	);

	// ****************************************
	// decode helpers
	// ****************************************
	assign wr_edge  = !q.sy2.wr_b && q.prv.wr_b && !q.sy2.cs_b;
	assign single   = !q.fifo_control_reg[FCR_EN] || !q.fifo_control_reg[FCR_DMA];
	assign allowed  = q.enhanced_feature_reg[EFR_ENH] && q.interrupt_enable_reg[IER_SLEEP];
	assign rx_held  = (fifo_i.rx_count != 7'h00);
	assign quiet    = rx_idle && fifo_i.tx_empty && fifo_i.tsr_empty
		&& !fifo_i.irq_other && !rx_held;
	assign wake     = (q.sy2.rx != q.prv.rx) || (q.sy2.mdm != q.prv.mdm)
		|| q.thr_wr;
	assign lsr_view = {fifo_i.rx_err, fifo_i.tx_empty && fifo_i.tsr_empty,
		fifo_i.tx_empty, 4'h0, rx_held};

	// read data selection
	always_comb begin
		unique case (q.sy2.a)
			A_THR_DLL: rd_mux = q.line_control_reg[LCR_DLAB] ? q.dll : 8'h00;
			A_IER_DLH: rd_mux = q.line_control_reg[LCR_DLAB] ? q.divisor_high_byte : q.interrupt_enable_reg;
			A_FCR_EFR: rd_mux = (q.line_control_reg == LCR_EFR_KEY) ? q.enhanced_feature_reg : q.fifo_control_reg;
			A_LCR:     rd_mux = q.line_control_reg;
			A_MCR:     rd_mux = q.modem_control_reg;
			A_LSR:     rd_mux = lsr_view;
			A_STAT:    rd_mux = {5'h00, rx_idle, q.slp == SLP_ASLEEP, single};
			default:   rd_mux = 8'h00;
		endcase
	end

	// ****************************************
	// next state
	// ****************************************
	// strobes and address are only read after two flops
	always_comb begin
		next_q = q;
		next_q.sy1 = pins;
		next_q.sy2 = q.sy1;
		next_q.prv = q.sy2;
		next_q.load = 1'b0;
		next_q.thr_wr = 1'b0;
		next_q.dout = rd_mux;
		if (loaded) begin
			next_q.wt = 1'b0;
		end
		// register writes
		if (wr_edge) begin
			unique case (q.sy2.a)
				A_THR_DLL: begin
					if (q.line_control_reg[LCR_DLAB]) begin
						next_q.dll = q.sy2.d;
						next_q.load = 1'b1;
						next_q.wt = 1'b1;
					end else begin
						next_q.thr_wr = 1'b1;
						next_q.thr_d = q.sy2.d;
					end
				end
				A_IER_DLH: begin
					if (q.line_control_reg[LCR_DLAB]) begin
						next_q.divisor_high_byte = q.sy2.d;
						next_q.load = 1'b1;
						next_q.wt = 1'b1;
					end else begin
						next_q.interrupt_enable_reg = q.sy2.d;
					end
				end
				A_FCR_EFR: begin
					if (q.line_control_reg == LCR_EFR_KEY) begin
						next_q.enhanced_feature_reg = q.sy2.d;
					end else begin
						next_q.fifo_control_reg = q.sy2.d;
					end
				end
				A_LCR:   next_q.line_control_reg = q.sy2.d;
				A_MCR:   next_q.modem_control_reg = q.sy2.d;
				default: next_q.line_control_reg = q.line_control_reg;
			endcase
		end
		// transmit dma request
		if (single) begin
			next_q.txrq = fifo_i.tx_empty;
		end else if (fifo_i.tx_full) begin
			next_q.txrq = 1'b0;
		end else if (fifo_i.tx_free >= fifo_i.tx_trig) begin
			next_q.txrq = 1'b1;
		end
		// receive dma request; empty or error outranks a new trigger
		if (single) begin
			next_q.rxrq = rx_held;
		end else if (!rx_held || fifo_i.rx_err) begin
			next_q.rxrq = 1'b0;
		end else if (fifo_i.rx_count >= fifo_i.rx_trig || fifo_i.rx_timeout) begin
			next_q.rxrq = 1'b1;
		end
		// sleep control; losing the enable also wakes the part
		unique case (q.slp)
			SLP_AWAKE: begin
				if (allowed && quiet && !wake) begin
					next_q.slp = SLP_ASLEEP;
				end
			end
			SLP_ASLEEP: begin
				if (wake || !allowed) begin
					next_q.slp = SLP_AWAKE;
				end
			end
		endcase
		// break forces the line low regardless of the transmitter
		next_q.txo = q.line_control_reg[LCR_BRK] ? 1'b0 : tx_data_i;
	end

	// ****************************************
	// state register
	// ****************************************
	// divisor bytes ride through reset; the MCR prescale bit does not, so the baud rate survives only with prescale off
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			q <= '{sy1: '1, sy2: '1, prv: '1, interrupt_enable_reg: REG_RST, line_control_reg: LCR_RST,
				fifo_control_reg: REG_RST, modem_control_reg: REG_RST, enhanced_feature_reg: REG_RST, dll: q.dll, divisor_high_byte: q.divisor_high_byte,
				txrq: 1'b1, rxrq: 1'b0, slp: SLP_AWAKE, load: 1'b0, wt: 1'b0,
				thr_wr: 1'b0, thr_d: 8'h00, dout: 8'h00, txo: 1'b1};
		end else begin
			q <= next_q;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign d_o                = q.dout;
	assign d_oe_o             = !q.sy2.cs_b && !q.sy2.rd_b;
	assign bus_wait_o         = q.wt;
	assign tx_serial_o        = q.txo;
	assign thr_write_o        = q.thr_wr;
	assign thr_data_o         = q.thr_d;
	assign tx_dma_request_b_o = !q.txrq;
	assign rx_dma_request_b_o = !q.rxrq;
	assign baud_tick16_o      = tick16;
	assign uart_clk_en_o      = (q.slp == SLP_AWAKE);
	assign rx_idle_o          = rx_idle;
	assign asleep_o           = (q.slp == SLP_ASLEEP);

	// ****************************************
	// checks
	// ****************************************
	chk_tx_single_req: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(single && !fifo_i.tx_empty) |=> tx_dma_request_b_o)
		else $error("tx request active with loaded transmitter");

	chk_rx_single_req: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(single && rx_held) |=> !rx_dma_request_b_o)
		else $error("rx request idle with data held");

	chk_tx_block_full: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!single && fifo_i.tx_full) |=> tx_dma_request_b_o)
		else $error("tx request active with full fifo");

	chk_rx_block_err: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!single && fifo_i.rx_err) |=> rx_dma_request_b_o)
		else $error("rx request active with fifo error");

	chk_sleep_enable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(asleep_o) |-> $past(allowed))
		else $error("sleep entered without enable");

	chk_sleep_rx_data: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!asleep_o && rx_held) |=> !asleep_o)
		else $error("sleep entered with receive data");

	chk_sleep_no_tick: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		asleep_o[*2] |-> !baud_tick16_o && !uart_clk_en_o)
		else $error("clocks running while asleep");

	chk_break_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		q.line_control_reg[LCR_BRK] |=> !tx_serial_o)
		else $error("break not driving line low");

	chk_div_wait: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_edge && q.line_control_reg[LCR_DLAB] && q.sy2.a == A_THR_DLL) |=> bus_wait_o ##1 bus_wait_o
		##1 !bus_wait_o)
		else $error("divisor write wait mis-timed");

endmodule : ud_uart_ctl
`default_nettype wire

//--- verification/ud_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host side of the parallel register bus
// ****************************************
module ud_host_model (
	input  wire logic       clk_i,   // system clock
	input  wire logic [7:0] rdata_i, // read data from device
	input  wire logic       wait_i,  // device wait state
	output logic            cs_b_o,  // chip select, low
	output logic            rd_b_o,  // read strobe, low
	output logic            wr_b_o,  // write strobe, low
	output logic      [2:0] a_o,     // address pins
	output logic      [7:0] d_o      // write data pins
);
	int unsigned extra = 0; // extra strobe cycles for a slow host

	// bus idle from time zero
	initial begin
		cs_b_o = 1'b1;
		rd_b_o = 1'b1;
		wr_b_o = 1'b1;
		a_o    = 3'h0;
		d_o    = 8'h00;
	end

	// strobe held past the device's wait state, then released
	task automatic wr(input logic [2:0] ad, input logic [7:0] dt);
		@(posedge clk_i);
		a_o    <= ad;
		d_o    <= dt;
		cs_b_o <= 1'b0;
		wr_b_o <= 1'b0;
		repeat (6 + extra) @(posedge clk_i);
		for (int i = 0; i < 16 && wait_i !== 1'b0; i++) @(posedge clk_i);
		cs_b_o <= 1'b1;
		wr_b_o <= 1'b1;
		d_o    <= ~dt; // released data must not keep showing the old byte
		repeat (3) @(posedge clk_i);
	endtask : wr

	// read data taken at the edge before the strobe goes away
	task automatic rd(input logic [2:0] ad, output logic [7:0] dt);
		@(posedge clk_i);
		a_o    <= ad;
		cs_b_o <= 1'b0;
		rd_b_o <= 1'b0;
		repeat (6 + extra) @(posedge clk_i);
		dt = rdata_i;
		cs_b_o <= 1'b1;
		rd_b_o <= 1'b1;
		repeat (3) @(posedge clk_i);
	endtask : rd
endmodule : ud_host_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ud_pkg::*;

	// ****************************************
	// signals
	// ****************************************
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        rx = 1'b1;
	logic  [3:0] mdm = 4'h0;
	logic        tx_bit = 1'b1;
	ud_fifo_s    fs;
	logic        cs_b, rd_b, wr_b, d_oe, bus_wait, tx_ser, thr_wr, tx_b, rx_b;
	logic        tick, clk_en, rx_idle, asleep, awake_seen, pr;
	logic        oe_seen, wait_seen;
	logic  [2:0] a;
	logic  [7:0] d_w, d_r, thr_d, thr_seen, b, v;
	logic [15:0] dv, ep, ex, obs;
	logic [15:0] exp_q[$];
	logic [15:0] dtab [4] = '{16'h0001, 16'h0003, 16'h0102, 16'h0000};
	logic        ptab [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	int          err_count = 0;
	int          tests_run = 0;
	int          n;
	int          ib = 4 * (5 + 3) + 12; // idle length in bits, 8-bit words
	integer      seed = 64;
	event        obs_ev;

	always #10 clk = ~clk;

	ud_uart_ctl DUT (
		.clk_i              (clk),
		.rst_b_i            (rst_b),
		.cs_b_i             (cs_b),
		.rd_b_i             (rd_b),
		.wr_b_i             (wr_b),
		.a_i                (a),
		.d_i                (d_w),
		.d_o                (d_r),
		.d_oe_o             (d_oe),
		.bus_wait_o         (bus_wait),
		.rx_i               (rx),
		.modem_i            (mdm),
		.tx_data_i          (tx_bit),
		.tx_serial_o        (tx_ser),
		.fifo_i             (fs),
		.thr_write_o        (thr_wr),
		.thr_data_o         (thr_d),
		.tx_dma_request_b_o (tx_b),
		.rx_dma_request_b_o (rx_b),
		.baud_tick16_o      (tick),
		.uart_clk_en_o      (clk_en),
		.rx_idle_o          (rx_idle),
		.asleep_o           (asleep)
	);

	ud_host_model host (
		.clk_i   (clk),
		.rdata_i (d_r),
		.wait_i  (bus_wait),
		.cs_b_o  (cs_b),
		.rd_b_o  (rd_b),
		.wr_b_o  (wr_b),
		.a_o     (a),
		.d_o     (d_w)
	);

	// ****************************************
	// scoreboard and watchers
	// ****************************************
	// every observed result meets the oldest expectation
	always @(obs_ev) begin
		tests_run++;
		ex = exp_q.pop_front();
		if (ex !== obs) begin
			err_count++;
			$display("MISMATCH at %0t exp %h got %h", $time, ex, obs);
		end
	end

	// wake, transmit write, drive enable and wait pulses may be short, so they are latched here
	always @(negedge clk) begin
		if (asleep !== 1'b1)
			awake_seen = 1'b1;
		if (thr_wr === 1'b1)
			thr_seen = thr_d;
		if (d_oe === 1'b1)
			oe_seen = 1'b1;
		if (bus_wait === 1'b1)
			wait_seen = 1'b1;
	end

	// hang guard, far above the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		summarize;
	end

	// ****************************************
	// tasks
	// ****************************************
	task settle(input int c);
		repeat (c) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task note(input logic [15:0] e);
		exp_q.push_back(e);
	endtask : note

	task look(input logic [15:0] g);
		obs = g;
		-> obs_ev;
		@(posedge clk);
	endtask : look

	task pins(input logic [1:0] e);
		settle(3);
		note({14'h0, e});
		look({14'h0, tx_b, rx_b});
	endtask : pins

	// cycles between two ticks, 300 meaning none seen
	task per(input logic [15:0] e);
		@(negedge clk);
		n = 0;
		while (tick !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tick !== 1'b1 && n < 300);
		note(e);
		look(16'(n));
	endtask : per

	// the bus drive enable must have shown during the read strobe
	task rchk(input logic [2:0] ad, input logic [7:0] e);
		oe_seen = 1'b0;
		host.rd(ad, v);
		note({7'h0, 1'b1, e});
		look({7'h0, oe_seen, v});
	endtask : rchk

	// both divisor bytes through the latch, then prescale select
	task div(input logic [15:0] dd, input logic p);
		host.wr(A_LCR, 8'h83);
		wait_seen = 1'b0;
		host.wr(A_THR_DLL, dd[7:0]);
		note(16'h1);
		look({15'h0, wait_seen});
		host.wr(A_IER_DLH, dd[15:8]);
		host.wr(A_LCR, 8'h03);
		host.wr(A_MCR, {p, 7'h00});
	endtask : div

	task do_reset;
		rst_b <= 1'b0;
		settle(10);
		note(16'h000D);
		look({11'h0, tx_b, rx_b, tx_ser, asleep, clk_en});
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : do_reset

	// must be asleep first, then one wake source is applied
	task slp_wake(input int src);
		settle(8);
		note(16'h1);
		look({15'h0, asleep});
		awake_seen = 1'b0;
		case (src)
			0: mdm <= ~mdm;
			1: host.wr(A_THR_DLL, b);
			default: rx <= 1'b0;
		endcase
		settle(12);
		note(16'h1);
		look({15'h0, awake_seen});
	endtask : slp_wake

	task summarize;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		fs = '0;
		fs.tx_trig = 7'd16;
		fs.rx_trig = 7'd8;
		fs.tx_empty = 1'b1;
		fs.tsr_empty = 1'b1;
		do_reset;
		rchk(A_LCR, LCR_RST);
		$display("reset test done");
		// fixed table first, then random divisors and host speeds
		for (int k = 0; k < 7; k++) begin
			if (k < 4) begin
				dv = dtab[k];
				pr = ptab[k];
			end else begin
				dv = 16'($random(seed) & 31) + 16'h0001;
				pr = 1'($random(seed));
				host.extra = $random(seed) & 3;
			end
			ep = (dv == 16'h0000) ? 16'd300 : (pr ? dv << 2 : dv);
			div(dv, pr);
			per(ep);
		end
		$display("baud test done");
		fs.tx_empty <= 1'b0;
		fs.rx_count <= 7'h1;
		pins(2'b10);
		fs.tx_empty <= 1'b1;
		fs.rx_count <= 7'h0;
		pins(2'b01);
		host.wr(A_FCR_EFR, 8'h08);
		fs.tx_empty <= 1'b0;
		pins(2'b11);
		fs.tx_full <= 1'b1;
		host.wr(A_FCR_EFR, 8'h09);
		pins(2'b11);
		fs.tx_full <= 1'b0;
		fs.tx_free <= 7'd15;
		fs.rx_count <= 7'd7;
		pins(2'b11);
		fs.tx_free <= 7'd16;
		fs.rx_count <= 7'd8;
		pins(2'b00);
		fs.tx_free <= 7'd15;
		fs.rx_err <= 1'b1;
		pins(2'b01);
		fs.tx_full <= 1'b1;
		fs.rx_err <= 1'b0;
		fs.rx_count <= 7'd3;
		fs.rx_timeout <= 1'b1;
		pins(2'b10);
		fs.rx_timeout <= 1'b0;
		pins(2'b10);
		fs.rx_count <= 7'd0;
		pins(2'b11);
		$display("dma test done");
		host.wr(A_LCR, 8'h43);
		settle(2);
		note(16'h0);
		look({15'h0, tx_ser});
		host.wr(A_LCR, 8'h03);
		settle(2);
		note(16'h1);
		look({15'h0, tx_ser});
		$display("break test done");
		// sleep enable bit still clear while the divisor changes
		div(16'h0001, 1'b0);
		host.wr(A_LCR, LCR_EFR_KEY);
		host.wr(A_FCR_EFR, 8'h10);
		host.wr(A_LCR, 8'h03);
		fs.tx_empty <= 1'b1;
		fs.rx_count <= 7'h1;
		host.wr(A_IER_DLH, 8'h10);
		rx <= 1'b0;
		repeat (40) @(posedge clk);
		rx <= 1'b1;
		n = 0;
		while (rx_idle !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		note(16'h1);
		look(16'(n >= ib * 16 - 16 && n <= ib * 16 + 24));
		settle(30);
		note(16'h0);
		look({15'h0, asleep});
		fs.rx_count <= 7'h0;
		settle(5);
		note(16'h2);
		look({14'h0, asleep, clk_en});
		per(16'd300);
		slp_wake(0);
		b = 8'($random(seed));
		slp_wake(1);
		note({8'h0, b});
		look({8'h0, thr_seen});
		slp_wake(2);
		host.wr(A_IER_DLH, 8'h00);
		rx <= 1'b1;
		repeat (ib * 16 + 60) @(posedge clk);
		settle(1);
		note(16'h2);
		look({14'h0, rx_idle, asleep});
		$display("sleep test done");
		do_reset;
		host.wr(A_LCR, 8'h83);
		rchk(A_THR_DLL, 8'h01);
		rchk(A_IER_DLH, 8'h00);
		$display("retention test done");
		summarize;
	end
endmodule : testbench
`default_nettype wire
